/* File: core/wake_pkg.sv */
// Function
// - Enabled wake source in power-off asserts reset
// - Sixteen-bit counter holds reset 65536 crystal periods
// - Unmasked wake source sets its pending bit
// - Masked wake source wakes, pending stays clear
// - Retention words survive power-off and wake reset
// - Retention words cleared only by pin/watchdog/rst_n_in
// - Alarm wake leaves alarm pending bit clear
// - Power-off GPIO outputs drive data, inputs stay
// - Special bit resets 0, needs strap3 and pin-wake
package wake_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_SCRATCH_A   = 12'h000;
    localparam logic [11:0] OFF_SCRATCH_B   = 12'h004;
    localparam logic [11:0] OFF_CLOCK_CTRL  = 12'h008;
    localparam logic [11:0] OFF_EXT_MASK    = 12'h00C;
    localparam logic [11:0] OFF_SRC_PEND    = 12'h010;
    localparam logic [11:0] OFF_EXT_PEND    = 12'h014;
    localparam logic [11:0] OFF_POWER_CTRL  = 12'h018;
    localparam logic [11:0] OFF_GPIO_DATA   = 12'h01C;
    localparam logic [11:0] OFF_GPIO_DIR    = 12'h020;
    localparam logic [11:0] OFF_STATUS      = 12'h024;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          EXT_LINES       = 8;
    localparam int          GPIO_PINS       = 8;
    localparam int          SPECIAL_BIT_POS = 0;
    localparam int          ALARM_SRC_POS   = 8;
    localparam logic [31:0] SCRATCH_RESET   = 32'h0000_0000;
    localparam logic [7:0]  MASK_RESET      = 8'hFF;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [15:0] WAKE_RST_COUNT  = 16'hFFFF;
    // Power states
    typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAKE} pwr_state_type;
endpackage

/* File: core/wake_reset_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts crystal periods while the wake reset is held
module wake_reset_timer
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic start_in,
    input  wire logic xtal_tick_in,
    output var  logic active_out
);
    logic [15:0] count_reg;   // Crystal periods elapsed
    logic        active_reg;  // Reset held
    wire         done = active_reg && xtal_tick_in && (count_reg == WAKE_RST_COUNT);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg  <= 16'h0000;
            active_reg <= 1'b0;
        end else if (start_in) begin
            count_reg  <= 16'h0000;
            active_reg <= 1'b1;
        end else if (done) begin
            active_reg <= 1'b0;
        end else if (active_reg && xtal_tick_in) begin
            count_reg  <= count_reg + 16'h0001;
        end
    end
    assign active_out = active_reg;

    // Reset is let go only at the terminal count
    property p_release_at_end;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(active_reg) |-> $past(count_reg) == WAKE_RST_COUNT;
    endproperty
    a_release_at_end: assert property (p_release_at_end) else $error("wake reset released early");
endmodule // wake_reset_timer
`default_nettype wire

/* File: core/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bus of levels
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;   // First stage, read only by second
    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // sync2
`default_nettype wire

/* File: core/power_off_wakeup_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Power-off wake-up sequencer with APB register access
module power_off_wakeup_sequencer
    import wake_pkg::*;
(
    // Clock and resets
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 external_reset_pin_n_in,
    input  wire logic                 watchdog_reset_in,
    // APB
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic [31:0]          prdata,
    output var  logic                 pready,
    output var  logic                 pslverr,
    // Wake sources and straps
    input  wire logic [EXT_LINES-1:0] ext_wake_in,
    input  wire logic                 rtc_alarm_in,
    input  wire logic                 xtal_clk_in,
    input  wire logic                 operating_mode_strap3_in,
    // Outputs
    output var  logic                 internal_reset_out,
    output var  logic                 power_off_out,
    output var  logic                 special_mode_out,
    output var  logic [GPIO_PINS-1:0] gpio_out,
    output var  logic [GPIO_PINS-1:0] gpio_oe_out
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [EXT_LINES+3:0] raw_in;     // Pin inputs before sync
    logic [EXT_LINES+3:0] sync_q;     // Synchronised pin inputs
    assign raw_in = {~external_reset_pin_n_in, operating_mode_strap3_in,
                     xtal_clk_in, rtc_alarm_in, ext_wake_in};
    sync2 #(.W(EXT_LINES+4)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .d_in       (raw_in),
        .q_out      (sync_q)
    );
    wire [EXT_LINES-1:0] ext_s    = sync_q[EXT_LINES-1:0];
    wire                 alarm_s  = sync_q[EXT_LINES];
    wire                 xtal_s   = sync_q[EXT_LINES+1];
    wire                 strap3_s = sync_q[EXT_LINES+2];
    wire                 pin_rst  = sync_q[EXT_LINES+3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pwr_state_type        state_reg;        // Power state
    logic                 xtal_d_reg;       // Crystal edge detect
    logic [31:0]          scratch_a_reg;    // Retention word A
    logic [31:0]          scratch_b_reg;    // Retention word B
    logic                 special_reg;      // Special-mode bit
    logic [EXT_LINES-1:0] ext_mask_reg;     // External mask
    logic [EXT_LINES-1:0] ext_pend_reg;     // External pending
    logic [EXT_LINES-1:0] wake_en_reg;      // Wake enables
    logic                 src_pend_reg;     // Source pending, external group
    logic                 pin_wake_reg;     // Last wake came from reset pin
    logic [GPIO_PINS-1:0] gpio_data_reg;    // Port data
    logic [GPIO_PINS-1:0] gpio_dir_reg;     // 1 = output
    logic                 rst_active;       // Wake reset held

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire xtal_tick = xtal_s & ~xtal_d_reg;
    wire wr        = psel & penable & pwrite;
    wire rd_hit    = (paddr <= OFF_STATUS) && (paddr[1:0] == 2'b00);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction
    wire [EXT_LINES-1:0] ext_fire = ext_s & wake_en_reg;
    wire wake     = (state_reg == ST_OFF) && ((|ext_fire) || alarm_s || pin_rst);
    wire ext_wake = (state_reg == ST_OFF) && (|ext_fire);
    wire [EXT_LINES-1:0] pend_set = ext_wake ? (ext_fire & ~ext_mask_reg)
                                             : {EXT_LINES{1'b0}};
    wire clear_words = pin_rst | watchdog_reset_in;

    // ------------------------------------------------------------
    // Wake reset timer
    // ------------------------------------------------------------
    wake_reset_timer u_timer (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .start_in     (wake),
        .xtal_tick_in (xtal_tick),
        .active_out   (rst_active)
    );

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg    <= ST_RUN;
            xtal_d_reg   <= 1'b0;
            pin_wake_reg <= 1'b0;
        end else begin
            xtal_d_reg <= xtal_s;
            case (state_reg)
                ST_RUN: begin
                    if (wr && hit(paddr, OFF_POWER_CTRL) && pwdata[0]) begin
                        state_reg <= ST_OFF;
                    end
                end
                ST_OFF: begin
                    if (wake) begin
                        state_reg    <= ST_WAKE;
                        pin_wake_reg <= pin_rst;
                    end
                end
                ST_WAKE: begin
                    if (!rst_active && !wake) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Retention words
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scratch_a_reg <= SCRATCH_RESET;
            scratch_b_reg <= SCRATCH_RESET;
        end else if (clear_words) begin
            scratch_a_reg <= SCRATCH_RESET;
            scratch_b_reg <= SCRATCH_RESET;
        end else if (wr && hit(paddr, OFF_SCRATCH_A)) begin
            scratch_a_reg <= pwdata;
        end else if (wr && hit(paddr, OFF_SCRATCH_B)) begin
            scratch_b_reg <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // Control registers and pending bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            special_reg   <= 1'b0;
            ext_mask_reg  <= MASK_RESET;
            wake_en_reg   <= '0;
            gpio_data_reg <= '0;
            gpio_dir_reg  <= '0;
        end else begin
            if (wr && hit(paddr, OFF_CLOCK_CTRL)) begin
                // Special mode only with strap3 and a pin wake
                special_reg <= pwdata[SPECIAL_BIT_POS] & strap3_s & pin_wake_reg;
            end
            if (wr && hit(paddr, OFF_EXT_MASK)) begin
                ext_mask_reg <= pwdata[EXT_LINES-1:0];
            end
            if (wr && hit(paddr, OFF_POWER_CTRL) && state_reg == ST_RUN) begin
                wake_en_reg <= pwdata[EXT_LINES+7:8];
            end
            if (wr && hit(paddr, OFF_GPIO_DATA) && state_reg == ST_RUN) begin
                gpio_data_reg <= pwdata[GPIO_PINS-1:0];
            end
            if (wr && hit(paddr, OFF_GPIO_DIR) && state_reg == ST_RUN) begin
                gpio_dir_reg <= pwdata[GPIO_PINS-1:0];
            end
        end
    end

    // Pending: write one to clear, a new set wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_pend_reg <= '0;
            src_pend_reg <= 1'b0;
        end else begin
            ext_pend_reg <= (ext_pend_reg & ~((wr && hit(paddr, OFF_EXT_PEND))
                            ? pwdata[EXT_LINES-1:0] : {EXT_LINES{1'b0}})) | pend_set;
            // Alarm wake never reaches the source pending register
            src_pend_reg <= (src_pend_reg & ~(wr && hit(paddr, OFF_SRC_PEND) && pwdata[0]))
                            | (|pend_set);
        end
    end

    // ------------------------------------------------------------
    // Outputs and APB answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            internal_reset_out <= 1'b0;
            power_off_out      <= 1'b0;
            special_mode_out   <= 1'b0;
            gpio_out           <= '0;
            gpio_oe_out        <= '0;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
        end else begin
            internal_reset_out <= wake | rst_active;
            power_off_out      <= (state_reg == ST_OFF);
            special_mode_out   <= special_reg;
            gpio_out           <= gpio_data_reg & gpio_dir_reg;
            gpio_oe_out        <= gpio_dir_reg;
            pready             <= psel & ~penable;
            pslverr            <= psel & ~penable & ~rd_hit;
            case (paddr)
                OFF_SCRATCH_A:  prdata <= scratch_a_reg;
                OFF_SCRATCH_B:  prdata <= scratch_b_reg;
                OFF_CLOCK_CTRL: prdata <= {31'h0, special_reg};
                OFF_EXT_MASK:   prdata <= {24'h0, ext_mask_reg};
                OFF_SRC_PEND:   prdata <= {31'h0, src_pend_reg};
                OFF_EXT_PEND:   prdata <= {24'h0, ext_pend_reg};
                OFF_POWER_CTRL: prdata <= {16'h0, wake_en_reg, 8'h0};
                OFF_GPIO_DATA:  prdata <= {24'h0, gpio_data_reg};
                OFF_GPIO_DIR:   prdata <= {24'h0, gpio_dir_reg};
                OFF_STATUS:     prdata <= {29'h0, pin_wake_reg, rst_active,
                                           state_reg == ST_OFF};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wake_reset;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        wake |=> internal_reset_out;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("no reset on wake");

    property p_reset_holds;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(rst_active) |=> rst_active [*8];
    endproperty
    a_reset_holds: assert property (p_reset_holds) else $error("reset too short");

    property p_pend_set;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ext_wake && |(ext_fire & ~ext_mask_reg) |=> src_pend_reg;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");

    property p_mask_clear;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (ext_mask_reg == 8'hFF) && $stable(ext_mask_reg) |=> $stable(src_pend_reg) || !src_pend_reg;
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("masked pending set");

    property p_keep_words;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !clear_words && !wr |=> $stable(scratch_a_reg) && $stable(scratch_b_reg);
    endproperty
    a_keep_words: assert property (p_keep_words) else $error("retention lost");

    property p_clear_words;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        clear_words |=> scratch_a_reg == 32'h0 && scratch_b_reg == 32'h0;
    endproperty
    a_clear_words: assert property (p_clear_words) else $error("retention not cleared");

    property p_alarm_no_pend;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        wake && !ext_wake && !src_pend_reg |=> !src_pend_reg;
    endproperty
    a_alarm_no_pend: assert property (p_alarm_no_pend) else $error("alarm set pending");

    property p_gpio_off;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        power_off_out |-> gpio_oe_out == gpio_dir_reg && gpio_out == (gpio_data_reg & gpio_dir_reg);
    endproperty
    a_gpio_off: assert property (p_gpio_off) else $error("gpio lost state");

    property p_special;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(special_reg) |-> $past(strap3_s) && $past(pin_wake_reg);
    endproperty
    a_special: assert property (p_special) else $error("illegal special mode");

    // Every unmasked line that woke the chip is pending afterwards
    property p_ext_pend_set;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (|pend_set) |=> (ext_pend_reg & $past(pend_set)) == $past(pend_set);
    endproperty
    a_ext_pend_set: assert property (p_ext_pend_set) else $error("line pending not set");

    // A masked line never raises its own pending bit
    property p_ext_pend_masked;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ext_wake |=> (ext_pend_reg & ~$past(ext_pend_reg) & $past(ext_mask_reg)) == {EXT_LINES{1'b0}};
    endproperty
    a_ext_pend_masked: assert property (p_ext_pend_masked) else $error("masked line pending");

    // Pins keep their state for as long as power-off lasts
    property p_gpio_hold;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        power_off_out && $past(power_off_out) |-> $stable(gpio_out) && $stable(gpio_oe_out);
    endproperty
    a_gpio_hold: assert property (p_gpio_hold) else $error("gpio changed in power-off");
endmodule // power_off_wakeup_sequencer
`default_nettype wire

/* File: tb/wake_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: external wake lines, alarm and crystal
module wake_source_model
    import wake_pkg::*;
(
    // Clock and wake reset seen from the device
    input  wire logic                 clk_sys_in,
    input  wire logic                 wake_reset_in,
    // Wake sources
    output var  logic [EXT_LINES-1:0] ext_wake_out,
    output var  logic                 rtc_alarm_out,
    output var  logic                 xtal_clk_out
);
    // Sources idle low from time zero
    initial begin
        ext_wake_out  = '0;
        rtc_alarm_out = 1'b0;
        xtal_clk_out  = 1'b0;
    end
    // Crystal runs free at half the system rate
    always @(posedge clk_sys_in) begin
        xtal_clk_out <= ~xtal_clk_out;
    end
    // Raise sources and hold them until the wake reset answers
    task automatic fire(input logic [EXT_LINES-1:0] lines, input logic alarm);
        int k;
        @(posedge clk_sys_in);
        ext_wake_out  <= lines;
        rtc_alarm_out <= alarm;
        k = 0;
        while (wake_reset_in !== 1'b1 && k < 40) begin
            @(posedge clk_sys_in);
            k++;
        end
        @(posedge clk_sys_in);
        ext_wake_out  <= '0;
        rtc_alarm_out <= 1'b0;
    endtask
endmodule // wake_source_model
`default_nettype wire

/* File: tb/tb_power_off_wakeup_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Compares two values and counts the outcome
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_power_off_wakeup_sequencer
    import wake_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 clk_sys_in, rst_n_in, external_reset_pin_n_in;
    logic                 watchdog_reset_in, operating_mode_strap3_in;
    logic                 psel, penable, pwrite, pready, pslverr, rd_err;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd_data;
    logic [EXT_LINES-1:0] ext_wake_in;
    logic                 rtc_alarm_in, xtal_clk_in;
    logic                 internal_reset_out, power_off_out, special_mode_out;
    logic [GPIO_PINS-1:0] gpio_out, gpio_oe_out;
    int                   fails, checked, cycles, n;
    // Device and its wake sources
    power_off_wakeup_sequencer dut (
        .clk_sys_in, .rst_n_in, .external_reset_pin_n_in, .watchdog_reset_in,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_wake_in, .rtc_alarm_in, .xtal_clk_in, .operating_mode_strap3_in,
        .internal_reset_out, .power_off_out, .special_mode_out, .gpio_out, .gpio_oe_out
    );
    wake_source_model src (
        .clk_sys_in, .wake_reset_in(internal_reset_out), .ext_wake_out(ext_wake_in),
        .rtc_alarm_out(rtc_alarm_in), .xtal_clk_out(xtal_clk_in)
    );
    // ------------------------------------------------------------
    // Clock, timeout and closing report
    // ------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // One long wake dominates the run time
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles > 200000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    // One APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (pready !== 1'b1 && k < 32);
        `CHK(pready, 1'b1)
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_data, e)
    endtask
    task automatic ticks(input int c);
        repeat (c) @(posedge clk_sys_in);
    endtask
    task automatic hard_reset();
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        ticks(5);
        rst_n_in <= 1'b1;
    endtask
    // Bounded wait for the wake reset to rise
    task automatic wait_wake();
        n = 0;
        while (internal_reset_out !== 1'b1 && n < 20) begin
            @(posedge clk_sys_in);
            n++;
        end
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, watchdog_reset_in, rst_n_in} = 5'h00;
        {paddr, pwdata} = 44'h0;
        external_reset_pin_n_in  = 1'b1;
        operating_mode_strap3_in = 1'b1;
        hard_reset();
        // Reset values and an unmapped place
        rd(OFF_SCRATCH_A, 32'h0000_0000);
        rd(OFF_SCRATCH_B, 32'h0000_0000);
        rd(OFF_CLOCK_CTRL, 32'h0000_0000);
        rd(OFF_EXT_MASK, 32'h0000_00FF);
        rd(OFF_EXT_PEND, 32'h0000_0000);
        apb(1'b0, 12'h028, 32'h0);
        `CHK({rd_err, rd_data}, 33'h1_0000_0000)
        $display("test reset_values done");
        // Watchdog wipes both retention words
        wr(OFF_SCRATCH_A, 32'h1234_5678);
        wr(OFF_SCRATCH_B, 32'h9ABC_DEF0);
        rd(OFF_SCRATCH_B, 32'h9ABC_DEF0);
        @(posedge clk_sys_in);
        watchdog_reset_in <= 1'b1;
        @(posedge clk_sys_in);
        watchdog_reset_in <= 1'b0;
        rd(OFF_SCRATCH_A, 32'h0000_0000);
        rd(OFF_SCRATCH_B, 32'h0000_0000);
        wr(OFF_SCRATCH_A, 32'hA5A5_0F0F);
        wr(OFF_SCRATCH_B, 32'h5A5A_F0F0);
        // Special mode refused without a pin wake
        wr(OFF_CLOCK_CTRL, 32'h0000_0001);
        rd(OFF_CLOCK_CTRL, 32'h0000_0000);
        `CHK(special_mode_out, 1'b0)
        $display("test watchdog_special done");
        // GPIO states held through power-off
        wr(OFF_GPIO_DATA, 32'h0000_00A5);
        wr(OFF_GPIO_DIR, 32'h0000_000F);
        wr(OFF_EXT_MASK, 32'h0000_00F7);
        wr(OFF_POWER_CTRL, 32'h0000_FF01);
        ticks(2);
        `CHK(power_off_out, 1'b1)
        wr(OFF_GPIO_DATA, 32'h0000_005A);
        `CHK({gpio_oe_out, gpio_out}, 16'h0F05)
        // Unmasked line wakes, sets pending, reset lasts the full count
        src.fire(8'h08, 1'b0);
        `CHK(internal_reset_out, 1'b1)
        `CHK(power_off_out, 1'b0)
        rd(OFF_EXT_PEND, 32'h0000_0008);
        rd(OFF_SRC_PEND, 32'h0000_0001);
        n = 0;
        while (internal_reset_out === 1'b1 && n < 140000) begin
            @(posedge clk_sys_in);
            n++;
        end
        `CHK(n >= 131040 && n <= 131080, 1'b1)
        rd(OFF_SCRATCH_A, 32'hA5A5_0F0F);
        rd(OFF_SCRATCH_B, 32'h5A5A_F0F0);
        wr(OFF_EXT_PEND, 32'h0000_0008);
        rd(OFF_EXT_PEND, 32'h0000_0000);
        wr(OFF_SRC_PEND, 32'h0000_0001);
        rd(OFF_SRC_PEND, 32'h0000_0000);
        $display("test full_wake done");
        // Masked line still wakes but leaves pending clear
        wr(OFF_EXT_MASK, 32'h0000_00FF);
        wr(OFF_POWER_CTRL, 32'h0000_2001);
        src.fire(8'h20, 1'b0);
        `CHK(internal_reset_out, 1'b1)
        rd(OFF_EXT_PEND, 32'h0000_0000);
        rd(OFF_SRC_PEND, 32'h0000_0000);
        hard_reset();
        $display("test masked_wake done");
        // Alarm wake leaves the alarm pending bit clear
        wr(OFF_EXT_MASK, 32'h0000_0000);
        wr(OFF_POWER_CTRL, 32'h0000_0001);
        src.fire(8'h00, 1'b1);
        `CHK(internal_reset_out, 1'b1)
        rd(OFF_SRC_PEND, 32'h0000_0000);
        hard_reset();
        $display("test alarm_wake done");
        // Pin wake clears retention and unlocks special mode
        wr(OFF_SCRATCH_A, 32'hCAFE_0001);
        wr(OFF_POWER_CTRL, 32'h0000_0001);
        @(posedge clk_sys_in);
        external_reset_pin_n_in <= 1'b0;
        ticks(4);
        external_reset_pin_n_in <= 1'b1;
        wait_wake();
        `CHK(internal_reset_out, 1'b1)
        rd(OFF_SCRATCH_A, 32'h0000_0000);
        wr(OFF_CLOCK_CTRL, 32'h0000_0001);
        rd(OFF_CLOCK_CTRL, 32'h0000_0001);
        `CHK(special_mode_out, 1'b1)
        hard_reset();
        rd(OFF_CLOCK_CTRL, 32'h0000_0000);
        $display("test pin_wake done");
        end_sim();
    end
endmodule // tb_power_off_wakeup_sequencer
`default_nettype wire
